// ---- src/cpp_pkg.sv ----
package cpp_pkg;
  // special-function register addresses
  localparam logic [7:0] CPP_ADDR_PORT_ZERO_LATCH    = 8'h80;
  localparam logic [7:0] CPP_ADDR_STACK_POINTER      = 8'h81;
  localparam logic [7:0] CPP_ADDR_DATA_PTR_ZERO_LOW  = 8'h82;
  localparam logic [7:0] CPP_ADDR_DATA_PTR_ZERO_HIGH = 8'h83;
  localparam logic [7:0] CPP_ADDR_DATA_PTR_ONE_LOW   = 8'h84;
  localparam logic [7:0] CPP_ADDR_DATA_PTR_ONE_HIGH  = 8'h85;
  localparam logic [7:0] CPP_ADDR_DATA_PTR_SELECT    = 8'h86;
  // addresses of the configuration registers that feed this bank
  localparam logic [7:0] CPP_ADDR_HW_CONFIG_ONE      = 8'h3e;
  localparam logic [7:0] CPP_ADDR_DRIVE_CFG_LOW      = 8'hac;
  localparam logic [7:0] CPP_ADDR_DRIVE_CFG_HIGH     = 8'had;
  // reset values
  localparam logic [7:0] CPP_RST_PORT_ZERO_LATCH     = 8'hff;
  localparam logic [7:0] CPP_RST_STACK_POINTER       = 8'h07;
  localparam logic [7:0] CPP_RST_DATA_PTR_BYTE       = 8'h00;
  localparam logic       CPP_RST_DATA_PTR_SELECT     = 1'b0;
  localparam logic [7:0] CPP_RST_READ_DATA           = 8'h00;
  // field positions and values
  localparam int         CPP_HW_CONFIG_ONE_BUS_BIT            = 1;
  localparam logic       CPP_HW_CONFIG_ONE_BUS_LEVEL          = 1'b1;
  localparam int         CPP_SEL_BIT                 = 0;
  localparam int         CPP_PINS_PER_CFG_REG        = 4;
  // per-pin drive types
  typedef enum logic [1:0] {
    CPP_DRV_OPEN_DRAIN = 2'h0,
    CPP_DRV_INPUT      = 2'h1,
    CPP_DRV_PUSH_PULL  = 2'h3,
    CPP_DRV_OPEN_ALT   = 2'h2
  } cpp_drive_type;
endpackage

// ---- src/cpp_core_pointer_bank.sv ----
`timescale 1ns/1ps
// Operation
// - port 0 is the multiplexed address/data bus when memory bus use is selected and general I/O otherwise; in bus use it is released outside external cycles.
// - in an external cycle port 0 carries the address low byte while the latch strobe is high, data while low.
// - bit 1 of the second hardware configuration register (3Eh) picks I/O use or memory bus use of port 0.
// - in I/O use each port 0 pin drive type comes from the drive configuration registers at ACh and ADh.
// - the stack pointer goes up by one before the byte of a push or call is written.
// - the stack pointer goes down by one after the byte of a pop, ret or reti is read.
// - the stack pointer is 07h after reset.
// - each data pointer is 16 bits, a low and a high byte register, each read and written on its own.
// - one select bit in the register at 86h picks the active data pointer.
// - with the select bit at 0, pointer instructions use the first pointer bytes.
// - with the select bit at 1, pointer instructions use the second pointer bytes.
module cpp_core_pointer_bank (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        srst,
  // special-function register access
  input  wire  logic [7:0]  sfr_addr,
  input  wire  logic        sfr_wr,
  input  wire  logic [7:0]  sfr_wdata,
  input  wire  logic        sfr_rd,
  output       logic [7:0]  sfr_rdata,
  output       logic        sfr_rvalid,
  // stack operations from the core
  input  wire  logic        stack_push,
  input  wire  logic        stack_pop,
  output       logic [7:0]  stack_pointer,
  // data pointer operations from the core
  input  wire  logic        active_data_pointer_load,
  input  wire  logic [15:0] active_data_pointer_load_value,
  input  wire  logic        active_data_pointer_inc,
  output       logic [15:0] active_data_pointer,
  output       logic        active_data_pointer_sel,
  // configuration registers
  input  wire  logic [7:0]  hw_config_one,
  input  wire  logic [7:0]  port_zero_drive_cfg_low,
  input  wire  logic [7:0]  port_zero_drive_cfg_high,
  // external memory cycle from the core
  input  wire  logic        ext_cycle,
  input  wire  logic        ext_ale,
  input  wire  logic        ext_write,
  input  wire  logic [7:0]  ext_addr_low,
  input  wire  logic [7:0]  ext_wdata,
  output       logic [7:0]  ext_rdata,
  // port 0 pins
  input  wire  logic [7:0]  p0_in,
  output       logic [7:0]  p0_out,
  output       logic [7:0]  p0_oe
);
  import cpp_pkg::*;

  function automatic logic sel_hit(input logic [7:0] a, input logic [7:0] off);
    sel_hit = (a == off);
  endfunction

  logic [7:0]  port_latch_q;
  logic [7:0]  sp_q;
  logic [7:0]  sp_d;
  logic        sel_q;
  logic [15:0] dp_q [2];
  logic [15:0] dp_d [2];
  logic [7:0]  pin_meta_q;
  logic [7:0]  pin_sync_q;
  logic [7:0]  p0_out_q;
  logic [7:0]  p0_oe_q;
  logic [7:0]  p0_out_d;
  logic [7:0]  p0_oe_d;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic        bus_mode;

  // port latch
  always_ff @(posedge clk) begin
    if (srst) begin
      port_latch_q <= CPP_RST_PORT_ZERO_LATCH;
    end else if (sfr_wr && sel_hit(sfr_addr, CPP_ADDR_PORT_ZERO_LATCH)) begin
      port_latch_q <= sfr_wdata;
    end
  end

  // stack pointer
  always_comb begin
    sp_d = sp_q;
    if (sfr_wr && sel_hit(sfr_addr, CPP_ADDR_STACK_POINTER)) begin
      sp_d = sfr_wdata;
    end else if (stack_push && !stack_pop) begin
      sp_d = 8'(sp_q + 8'h01);
    end else if (stack_pop && !stack_push) begin
      sp_d = 8'(sp_q - 8'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sp_q <= CPP_RST_STACK_POINTER;
    end else begin
      sp_q <= sp_d;
    end
  end

  // pointer select
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_q <= CPP_RST_DATA_PTR_SELECT;
    end else if (sfr_wr && sel_hit(sfr_addr, CPP_ADDR_DATA_PTR_SELECT)) begin
      sel_q <= sfr_wdata[CPP_SEL_BIT];
    end
  end

  // data pointers
  generate
    for (genvar i = 0; i < 2; i++) begin : g_dp
      localparam logic [7:0] LOW_ADDR  = (i == 0) ? CPP_ADDR_DATA_PTR_ZERO_LOW  : CPP_ADDR_DATA_PTR_ONE_LOW;
      localparam logic [7:0] HIGH_ADDR = (i == 0) ? CPP_ADDR_DATA_PTR_ZERO_HIGH : CPP_ADDR_DATA_PTR_ONE_HIGH;
      logic active;
      assign active = (sel_q == 1'(i));
      always_comb begin
        dp_d[i] = dp_q[i];
        if (active && active_data_pointer_load) begin
          dp_d[i] = active_data_pointer_load_value;
        end else if (active && active_data_pointer_inc) begin
          dp_d[i] = 16'(dp_q[i] + 16'h0001);
        end
        if (sfr_wr && sel_hit(sfr_addr, LOW_ADDR)) begin
          dp_d[i][7:0] = sfr_wdata;
        end
        if (sfr_wr && sel_hit(sfr_addr, HIGH_ADDR)) begin
          dp_d[i][15:8] = sfr_wdata;
        end
      end
      always_ff @(posedge clk) begin
        if (srst) begin
          dp_q[i] <= {CPP_RST_DATA_PTR_BYTE, CPP_RST_DATA_PTR_BYTE};
        end else begin
          dp_q[i] <= dp_d[i];
        end
      end
    end
  endgenerate

  assign active_data_pointer = sel_q ? dp_q[1] : dp_q[0];
  assign active_data_pointer_sel            = sel_q;
  assign stack_pointer       = sp_q;

  // register read port
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q  <= CPP_RST_READ_DATA;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= sfr_rd;
      if (!sfr_rd) begin
        rdata_q <= rdata_q;
      end else if (sel_hit(sfr_addr, CPP_ADDR_PORT_ZERO_LATCH)) begin
        rdata_q <= pin_sync_q;
      end else if (sel_hit(sfr_addr, CPP_ADDR_STACK_POINTER)) begin
        rdata_q <= sp_q;
      end else if (sel_hit(sfr_addr, CPP_ADDR_DATA_PTR_ZERO_LOW)) begin
        rdata_q <= dp_q[0][7:0];
      end else if (sel_hit(sfr_addr, CPP_ADDR_DATA_PTR_ZERO_HIGH)) begin
        rdata_q <= dp_q[0][15:8];
      end else if (sel_hit(sfr_addr, CPP_ADDR_DATA_PTR_ONE_LOW)) begin
        rdata_q <= dp_q[1][7:0];
      end else if (sel_hit(sfr_addr, CPP_ADDR_DATA_PTR_ONE_HIGH)) begin
        rdata_q <= dp_q[1][15:8];
      end else if (sel_hit(sfr_addr, CPP_ADDR_DATA_PTR_SELECT)) begin
        rdata_q <= {7'h00, sel_q};
      end else begin
        rdata_q <= CPP_RST_READ_DATA;
      end
    end
  end

  assign sfr_rdata  = rdata_q;
  assign sfr_rvalid = rvalid_q;

  // pin synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= p0_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign ext_rdata = pin_sync_q;

  // port 0 drive
  assign bus_mode = (hw_config_one[CPP_HW_CONFIG_ONE_BUS_BIT] == CPP_HW_CONFIG_ONE_BUS_LEVEL);

  generate
    for (genvar p = 0; p < 8; p++) begin : g_pin
      cpp_drive_type mode;
      if (p < CPP_PINS_PER_CFG_REG) begin : g_lo
        assign mode = cpp_drive_type'(port_zero_drive_cfg_low[2*p +: 2]);
      end else begin : g_hi
        assign mode = cpp_drive_type'(port_zero_drive_cfg_high[2*(p-CPP_PINS_PER_CFG_REG) +: 2]);
      end
      always_comb begin
        p0_out_d[p] = 1'b0;
        p0_oe_d[p]  = 1'b0;
        if (bus_mode) begin
          if (ext_cycle && ext_ale) begin
            p0_out_d[p] = ext_addr_low[p];
            p0_oe_d[p]  = 1'b1;
          end else if (ext_cycle && ext_write) begin
            p0_out_d[p] = ext_wdata[p];
            p0_oe_d[p]  = 1'b1;
          end
        end else begin
          case (mode)
            CPP_DRV_PUSH_PULL: begin
              p0_out_d[p] = port_latch_q[p];
              p0_oe_d[p]  = 1'b1;
            end
            CPP_DRV_INPUT: begin
              p0_oe_d[p] = 1'b0;
            end
            default: begin
              p0_oe_d[p] = ~port_latch_q[p];
            end
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      p0_out_q <= 8'h00;
      p0_oe_q  <= 8'h00;
    end else begin
      p0_out_q <= p0_out_d;
      p0_oe_q  <= p0_oe_d;
    end
  end

  assign p0_out = p0_out_q;
  assign p0_oe  = p0_oe_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sp_reset_value_a: assert property (@(posedge clk) disable iff (1'b0) srst |=> sp_q == 8'h07)
    else $error("stack pointer not 07h after reset");
  sp_push_inc_a: assert property (stack_push && !stack_pop && !(sfr_wr && sfr_addr == 8'h81)
    |=> sp_q == 8'($past(sp_q) + 8'h01))
    else $error("push did not raise stack pointer by one");
  sp_pop_dec_a: assert property (stack_pop && !stack_push && !(sfr_wr && sfr_addr == 8'h81)
    |=> sp_q == 8'($past(sp_q) - 8'h01))
    else $error("pop did not lower stack pointer by one");
  sel_zero_use_a: assert property (!sel_q |-> active_data_pointer == {dp_q[0][15:8], dp_q[0][7:0]})
    else $error("select 0 not using first pointer");
  sel_one_use_a: assert property (sel_q |-> active_data_pointer == dp_q[1])
    else $error("select 1 not using second pointer");
  sel_write_a: assert property (sfr_wr && sfr_addr == 8'h86 |=> sel_q == $past(sfr_wdata[0]))
    else $error("select bit not written");
  sel_upper_zero_a: assert property (sfr_rd && sfr_addr == 8'h86 |=> sfr_rvalid && sfr_rdata[7:1] == 7'h00)
    else $error("select upper bits not zero");
  dp_byte_write_a: assert property (sfr_wr && sfr_addr == 8'h84
    |=> dp_q[1][7:0] == $past(sfr_wdata) && dp_q[1][15:8] == $past(dp_q[1][15:8]))
    else $error("pointer low byte write not separate");
  bus_addr_phase_a: assert property (bus_mode && ext_cycle && ext_ale
    |=> p0_oe == 8'hff && p0_out == $past(ext_addr_low))
    else $error("address low byte not on port during strobe high");
  bus_data_phase_a: assert property (bus_mode && ext_cycle && !ext_ale && ext_write
    |=> p0_oe == 8'hff && p0_out == $past(ext_wdata))
    else $error("data not on port during strobe low");
  gpio_push_pull_a: assert property (!bus_mode && port_zero_drive_cfg_low[1:0] == 2'h3
    |=> p0_oe[0] && p0_out[0] == $past(port_latch_q[0]))
    else $error("push-pull pin not driving latch");
  bus_select_a: assert property (bus_mode && !(ext_cycle && (ext_ale || ext_write)) |=> p0_oe == 8'h00)
    else $error("port mode select ignored");
endmodule

// ---- sim/cpp_ext_mem.sv ----
`timescale 1ns/1ps
// external memory on the port 0 bus; p0_in toggles every cycle unless io forces io_val or a read data phase returns mem
module cpp_ext_mem (
  // clock
  input  wire  logic       clk,
  // strobes from the core side
  input  wire  logic       ale,
  input  wire  logic       rd,
  // pin level forced while port 0 is general i/o
  input  wire  logic       io,
  input  wire  logic [7:0] io_val,
  // port 0 pins
  input  wire  logic [7:0] p0_out,
  input  wire  logic [7:0] p0_oe,
  output       logic [7:0] p0_in
);
  logic [7:0] mem [256];
  logic [7:0] a_q;
  logic       ale_q;
  logic       rd_q;
  initial p0_in = 8'h5a;
  always @(posedge clk) begin
    ale_q <= ale;
    rd_q  <= rd;
    if (ale_q && p0_oe == 8'hff) a_q <= p0_out;
    else if (p0_oe == 8'hff) mem[a_q] <= p0_out;
    if (io) p0_in <= io_val;
    else if (rd_q && !ale_q) p0_in <= mem[a_q];
    else p0_in <= ~p0_in;
  end
endmodule

// ---- sim/cpp_core_pointer_bank_tb_top.sv ----
`timescale 1ns/1ps
module cpp_core_pointer_bank_tb_top;
  import cpp_pkg::*;
  logic        clk = 0, srst = 1, sfr_wr = 0, sfr_rd = 0, push = 0, pop = 0, ld = 0, inc = 0;
  logic        cyc = 0, ale = 0, wrx = 0, io = 1, rvalid, sel;
  logic [7:0]  sfr_addr = 0, sfr_wdata = 0, hcr = 0, cfg_l = 0, cfg_h = 0, eaddr = 0, ewd = 0;
  logic [7:0]  io_val = 8'hff, rdata, sp, erd, p0_in, p0_out, p0_oe;
  logic [15:0] ld_val = 0, adp;
  int          n_fail = 0, check_count = 0;
  always #50 clk = ~clk;
  cpp_core_pointer_bank dut_u (.clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(rdata), .sfr_rvalid(rvalid), .stack_push(push),
    .stack_pop(pop), .stack_pointer(sp), .active_data_pointer_load(ld), .active_data_pointer_load_value(ld_val), .active_data_pointer_inc(inc),
    .active_data_pointer(adp), .active_data_pointer_sel(sel), .hw_config_one(hcr), .port_zero_drive_cfg_low(cfg_l),
    .port_zero_drive_cfg_high(cfg_h), .ext_cycle(cyc), .ext_ale(ale), .ext_write(wrx), .ext_addr_low(eaddr),
    .ext_wdata(ewd), .ext_rdata(erd), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe));
  cpp_ext_mem mem_u (.clk(clk), .ale(ale), .rd(cyc & ~wrx), .io(io), .io_val(io_val), .p0_out(p0_out),
    .p0_oe(p0_oe), .p0_in(p0_in));
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(negedge clk);
    sfr_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(negedge clk);
    sfr_rd = 0;
    chk({7'h0, rvalid, rdata}, {8'h01, e});
  endtask
  task op(input logic [3:0] v);
    @(negedge clk);
    {push, pop, ld, inc} = v;
    @(negedge clk);
    {push, pop, ld, inc} = 4'h0;
  endtask
  task t_reset;
    logic [7:0] rv [8] = '{8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (2) @(negedge clk);
    for (int i = 0; i < 8; i++) rd(8'h80 + 8'(i), rv[i]);
    chk({7'h0, sel, sp}, 16'h0007);
    chk(adp, 16'h0000);
  endtask
  task t_stack;
    repeat (3) op(4'h8);
    chk(sp, 8'h0a);
    op(4'h4);
    chk(sp, 8'h09);
    op(4'hc);
    chk(sp, 8'h09);
    wr(CPP_ADDR_STACK_POINTER, 8'hff);
    op(4'h8);
    rd(CPP_ADDR_STACK_POINTER, 8'h00);
  endtask
  task t_active_data_pointer;
    for (int i = 0; i < 4; i++) wr(8'h82 + 8'(i), 8'h10 + 8'(i));
    for (int i = 0; i < 4; i++) rd(8'h82 + 8'(i), 8'h10 + 8'(i));
    chk(adp, 16'h1110);
    wr(CPP_ADDR_DATA_PTR_SELECT, 8'hff);
    rd(CPP_ADDR_DATA_PTR_SELECT, 8'h01);
    chk(adp, 16'h1312);
    wr(CPP_ADDR_DATA_PTR_ONE_LOW, 8'hff);
    op(4'h1);
    chk(adp, 16'h1400);
    wr(CPP_ADDR_DATA_PTR_SELECT, 8'h00);
    ld_val = 16'hbeef;
    op(4'h2);
    chk(adp, 16'hbeef);
    rd(CPP_ADDR_DATA_PTR_ONE_HIGH, 8'h14);
    rd(CPP_ADDR_DATA_PTR_ZERO_LOW, 8'hef);
  endtask
  function logic [15:0] iox(input logic [7:0] l, input logic [15:0] c);
    logic [7:0] o, e;
    for (int n = 0; n < 8; n++) begin
      e[n] = c[2*n+:2] == 2'h3 ? 1'b1 : c[2*n+:2] == 2'h1 ? 1'b0 : ~l[n];
      o[n] = c[2*n+:2] == 2'h3 && l[n];
    end
    return {o, e};
  endfunction
  task t_io;
    logic [15:0] cf [5] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff, 16'h00ff};
    hcr = 8'hfd;
    wr(CPP_ADDR_PORT_ZERO_LATCH, 8'h3c);
    for (int k = 0; k < 5; k++) begin
      {cfg_h, cfg_l} = cf[k];
      repeat (2) @(negedge clk);
      chk({p0_out & p0_oe, p0_oe}, iox(8'h3c, cf[k]));
    end
    io_val = 8'hc3;
    repeat (4) @(negedge clk);
    rd(CPP_ADDR_PORT_ZERO_LATCH, 8'hc3);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {cyc, ale, wrx, eaddr, ewd} = {2'b11, w, a, d};
    @(negedge clk);
    chk({p0_out, p0_oe}, {a, 8'hff});
    ale = 0;
    @(negedge clk);
    chk({p0_out & p0_oe, p0_oe}, w ? {d, 8'hff} : 16'h0000);
    repeat (5) @(negedge clk);
    cyc = 0;
    if (!w) chk(erd, d);
    @(negedge clk);
    chk(p0_oe, 8'h00);
  endtask
  task t_bus;
    io = 0;
    hcr = 8'h02;
    bus(1, 8'h12, 8'h9e);
    bus(1, 8'h34, 8'h61);
    bus(0, 8'h12, 8'h9e);
    bus(0, 8'h34, 8'h61);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    srst = 0;
    t_reset;
    t_stack;
    t_active_data_pointer;
    t_io;
    t_bus;
    wrap_up;
  end
  initial begin
    #400000;
    n_fail++;
    wrap_up;
  end
endmodule
